// ==== tvui_pkg.sv ====
// tvui_pkg: register map, field positions, source numbers and vector
// arithmetic of the two-level vectored interrupt unit.
// assumes: used through tvui_pkg::name only, nothing imported.
package tvui_pkg;

    // ****************************************************************
    // sizes and reset values
    // ****************************************************************
    localparam int unsigned NSRC     = 22;
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [21:0] RST_SRC  = 22'h000000;

    // ****************************************************************
    // register byte addresses (apb, one word each)
    // ****************************************************************
    localparam logic [7:0] ADDR_TCTL = 8'h00; // timer_control_reg
    localparam logic [7:0] ADDR_ENB  = 8'h04; // enable_reg_base
    localparam logic [7:0] ADDR_EN1  = 8'h08; // enable_reg_ext1
    localparam logic [7:0] ADDR_EN2  = 8'h0c; // enable_reg_ext2
    localparam logic [7:0] ADDR_PRB  = 8'h10; // priority_reg_base
    localparam logic [7:0] ADDR_PR1  = 8'h14; // priority_reg_ext1
    localparam logic [7:0] ADDR_PR2  = 8'h18; // priority_reg_ext2
    localparam logic [7:0] ADDR_PEND = 8'h1c; // all pending flags
    localparam logic [7:0] ADDR_P1IF = 8'h20; // port_one_irq_flags
    localparam logic [7:0] ADDR_STAT = 8'h24; // unit status

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned TC_TYPE_A  = 0;
    localparam int unsigned TC_PEND_A  = 1;
    localparam int unsigned TC_TYPE_B  = 2;
    localparam int unsigned TC_PEND_B  = 3;
    localparam int unsigned TC_PEND_T0 = 5;
    localparam int unsigned TC_PEND_T1 = 7;
    localparam int unsigned EN_GLOBAL  = 7;
    localparam int unsigned P1IF_LO    = 4;
    localparam int unsigned BASE_CNT   = 6;  // sources in base registers
    localparam int unsigned EXT1_LO    = 6;  // first source of ext1
    localparam int unsigned EXT2_LO    = 14; // first source of ext2

    // ****************************************************************
    // source numbers (fixed priority order)
    // ****************************************************************
    localparam int unsigned SRC_PIN_A  = 0;
    localparam int unsigned SRC_T0     = 1;
    localparam int unsigned SRC_PIN_B  = 2;
    localparam int unsigned SRC_T1     = 3;
    localparam int unsigned SRC_T2     = 5;
    localparam int unsigned SRC_CA     = 9;
    localparam int unsigned SRC_EXT4   = 16;
    localparam int unsigned SRC_UNUSED = 20;
    localparam int unsigned SRC_XTAL   = 21;

    // ****************************************************************
    // vectors
    // ****************************************************************
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int unsigned VEC_SHIFT = 3; // eight-byte slots

    // arbitration result
    typedef struct packed {
        logic       valid;
        logic       hi;
        logic [4:0] idx;
    } tvui_win_t;

    // lowest set bit wins
    function automatic logic [4:0] first_idx(input logic [21:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : first_idx

    // vector address of a source
    function automatic logic [15:0] vec_of(input logic [4:0] idx);
        return VEC_BASE + (16'(idx) << VEC_SHIFT);
    endfunction : vec_of

endpackage : tvui_pkg

// ==== tvui_sense.sv ====
// tvui_sense: synchroniser and falling-edge detect for active-low pins.
// assumes: pins are asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module tvui_sense #(
    parameter int unsigned N = 6
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] pin_n,
    output logic      [N-1:0] low,
    output logic      [N-1:0] fall
);
    logic [N-1:0] s1_q, s2_q, s3_q;
    logic [N-1:0] s1_d, s2_d, s3_d;

    // ****************************************************************
    // two-stage sync plus one history stage
    // ****************************************************************
    always_comb begin
        s1_d = pin_n;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // active-low level and high-to-low transition
    assign low  = ~s2_q;
    assign fall = s3_q & ~s2_q;

endmodule : tvui_sense
`default_nettype wire

// ==== tvui_arb.sv ====
// tvui_arb: two-level priority decode with in-service blocking.
// assumes: req already masked by enables; pure combinational.
`timescale 1ns/1ns
`default_nettype none
module tvui_arb (
    input  wire logic [21:0]         req,
    input  wire logic [21:0]         pri,
    input  wire logic                ins_lo,
    input  wire logic                ins_hi,
    output tvui_pkg::tvui_win_t      win
);
    logic [21:0] hi_req;
    logic [21:0] lo_req;

    // ****************************************************************
    // high level first, then fixed order within a level
    // ****************************************************************
    always_comb begin
        hi_req = req & pri;
        lo_req = req & ~pri;
        win    = '0;
        if (|hi_req && !ins_hi) begin
            win.valid = 1'b1;
            win.hi    = 1'b1;
            win.idx   = tvui_pkg::first_idx(hi_req);
        end else if (|lo_req && !ins_hi && !ins_lo) begin
            win.valid = 1'b1;
            win.hi    = 1'b0;
            win.idx   = tvui_pkg::first_idx(lo_req);
        end
    end

endmodule : tvui_arb
`default_nettype wire

// ==== tvui_unit.sv ====
// tvui_unit: two-level vectored interrupt unit, apb registers, core port.
// assumes: core, peripherals and apb master run on mclk; pins are async.
//
// Overview of operation
// RULE_01 - pins a, b: low level or falling edge
// RULE_02 - pins a, b pending in control bits 1, 3
// RULE_03 - edge pending cleared when core vectors
// RULE_04 - level mode pending follows the pin
// RULE_05 - source holds level until recognised
// RULE_06 - source releases level before routine ends
// RULE_07 - ext 4-7 falling edge, flags bits 4-7
// RULE_08 - vectors 0x0003 upward in eight-byte steps
// RULE_09 - counter array flags share one vector
// RULE_10 - timer two flags share one vector
// RULE_11 - comparator edges have own vectors
// RULE_12 - per-source priority bit, reset low
// RULE_13 - high preempts low, high never preempted
// RULE_14 - higher level first, then lowest number
// RULE_15 - sample and decode every clock
// RULE_16 - one clock detect then four-clock call
// RULE_17 - one instruction after return before call
// RULE_18 - longest unblocked response eighteen clocks
// RULE_19 - equal or higher routine blocks until return
// RULE_20 - flags set even when source disabled
// RULE_21 - global enable gates every source
// RULE_22 - software set of flag raises request
// RULE_23 - flag still set after return re-enters
// RULE_24 - one in-service marker per level
// RULE_25 - vector and request out, acknowledge in
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module tvui_unit (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external request pins, active low
    input  wire logic        ext_req_pin_a_n,
    input  wire logic        ext_req_pin_b_n,
    input  wire logic [3:0]  ext47_pin_n,
    // peripheral set pulses
    input  wire logic [21:0] periph_set,
    input  wire logic        timer_two_overflow_flag,
    input  wire logic        timer_two_ext_flag,
    input  wire logic        counter_array_overflow,
    input  wire logic [4:0]  counter_module_flag,
    input  wire logic        crystal_ready_flag,
    // core side
    input  wire logic        instr_boundary,
    input  wire logic        call_ack,
    input  wire logic        irq_return_instr_done,
    output logic             call_req,
    output logic      [15:0] call_vector,
    output logic             in_service_lo,
    output logic             in_service_hi
);
    logic [21:0] pend_q, pend_d, en_q, en_d, pri_q, pri_d;
    logic [1:0]  trig_q, trig_d;
    logic        glob_q, glob_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d, rdata;
    logic        addr_ok, wr_en;
    logic [21:0] sw_mask, sw_val, hw_set, elig;
    logic [5:0]  pin_low, pin_fall;
    tvui_pkg::tvui_win_t win;
    logic        req_q, req_d, hi_q, hi_d, hold_q, hold_d;
    logic        ins_lo_q, ins_lo_d, ins_hi_q, ins_hi_d;
    logic [4:0]  idx_q, idx_d;
    logic [15:0] vec_q, vec_d;
    logic        ack_take;

    // ****************************************************************
    // pin sensing
    // ****************************************************************
    tvui_sense #(.N(6)) u_sense (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin_n ({ext47_pin_n, ext_req_pin_b_n, ext_req_pin_a_n}),
        .low   (pin_low),
        .fall  (pin_fall)
    );

    // ****************************************************************
    // apb slave: one wait state, registered answer
    // ****************************************************************
    assign wr_en = psel & penable & pwrite & pready_q;

    // read mux and address check
    always_comb begin
        rdata   = 32'h00000000;
        addr_ok = 1'b1;
        unique case (paddr)
            tvui_pkg::ADDR_TCTL: begin
                rdata[tvui_pkg::TC_TYPE_A]  = trig_q[0];
                rdata[tvui_pkg::TC_PEND_A]  = pend_q[tvui_pkg::SRC_PIN_A]; // see RULE_02
                rdata[tvui_pkg::TC_TYPE_B]  = trig_q[1];
                rdata[tvui_pkg::TC_PEND_B]  = pend_q[tvui_pkg::SRC_PIN_B];
                rdata[tvui_pkg::TC_PEND_T0] = pend_q[tvui_pkg::SRC_T0];
                rdata[tvui_pkg::TC_PEND_T1] = pend_q[tvui_pkg::SRC_T1];
            end
            tvui_pkg::ADDR_ENB: begin
                rdata[5:0]                 = en_q[5:0];
                rdata[tvui_pkg::EN_GLOBAL] = glob_q;
            end
            tvui_pkg::ADDR_EN1:  rdata[7:0]  = en_q[13:6];
            tvui_pkg::ADDR_EN2:  rdata[7:0]  = en_q[21:14];
            tvui_pkg::ADDR_PRB:  rdata[5:0]  = pri_q[5:0];
            tvui_pkg::ADDR_PR1:  rdata[7:0]  = pri_q[13:6];
            tvui_pkg::ADDR_PR2:  rdata[7:0]  = pri_q[21:14];
            tvui_pkg::ADDR_PEND: rdata[21:0] = pend_q;
            tvui_pkg::ADDR_P1IF: rdata[7:4]  = pend_q[19:16];
            tvui_pkg::ADDR_STAT: rdata[12:0] = {idx_q, 5'h00, req_q, ins_hi_q, ins_lo_q};
            default:             addr_ok     = 1'b0;
        endcase
    end

    // answer registers
    always_comb begin
        pready_d  = psel & penable & ~pready_q;
        prdata_d  = pready_d ? rdata : prdata_q;
        pslverr_d = pready_d & ~addr_ok;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ****************************************************************
    // control registers: trigger type, enables, priorities
    // ****************************************************************
    always_comb begin
        trig_d = trig_q;
        en_d   = en_q;
        pri_d  = pri_q;
        glob_d = glob_q;
        if (wr_en) begin
            unique case (paddr)
                tvui_pkg::ADDR_TCTL: trig_d = {pwdata[tvui_pkg::TC_TYPE_B],
                                               pwdata[tvui_pkg::TC_TYPE_A]}; // see RULE_01
                tvui_pkg::ADDR_ENB: begin
                    en_d[5:0] = pwdata[5:0];
                    glob_d    = pwdata[tvui_pkg::EN_GLOBAL]; // see RULE_21
                end
                tvui_pkg::ADDR_EN1: en_d[13:6]   = pwdata[7:0];
                tvui_pkg::ADDR_EN2: en_d[21:14]  = pwdata[7:0];
                tvui_pkg::ADDR_PRB: pri_d[5:0]   = pwdata[5:0];   // see RULE_12
                tvui_pkg::ADDR_PR1: pri_d[13:6]  = pwdata[7:0];
                tvui_pkg::ADDR_PR2: pri_d[21:14] = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q <= 2'h0;
            en_q   <= tvui_pkg::RST_SRC;
            pri_q  <= tvui_pkg::RST_SRC; // all low after reset, see RULE_12
            glob_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
            en_q   <= en_d;
            pri_q  <= pri_d;
            glob_q <= glob_d;
        end
    end

    // ****************************************************************
    // pending flags
    // ****************************************************************
    // software write lanes into the flags
    always_comb begin
        sw_mask = 22'h000000;
        sw_val  = 22'h000000;
        if (wr_en) begin
            unique case (paddr)
                tvui_pkg::ADDR_TCTL: begin
                    sw_mask[3:0] = 4'hf;
                    sw_val[3:0]  = {pwdata[tvui_pkg::TC_PEND_T1], pwdata[tvui_pkg::TC_PEND_B],
                                    pwdata[tvui_pkg::TC_PEND_T0], pwdata[tvui_pkg::TC_PEND_A]};
                end
                tvui_pkg::ADDR_PEND: begin
                    sw_mask = 22'h3fffff;
                    sw_val  = pwdata[21:0];
                end
                tvui_pkg::ADDR_P1IF: begin
                    sw_mask[19:16] = 4'hf;
                    sw_val[19:16]  = pwdata[7:4]; // see RULE_07
                end
                default: ;
            endcase
        end
    end

    // hardware set events, shared vectors merged
    always_comb begin
        hw_set = periph_set;
        hw_set[tvui_pkg::SRC_PIN_A] = pin_fall[0] & trig_q[0];
        hw_set[tvui_pkg::SRC_PIN_B] = pin_fall[1] & trig_q[1];
        hw_set[tvui_pkg::SRC_T2] = periph_set[tvui_pkg::SRC_T2] | timer_two_overflow_flag
                                   | timer_two_ext_flag;                   // see RULE_10
        hw_set[tvui_pkg::SRC_CA] = periph_set[tvui_pkg::SRC_CA] | counter_array_overflow
                                   | (|counter_module_flag);               // see RULE_09
        hw_set[19:16] = pin_fall[5:2];                                     // see RULE_07
        hw_set[tvui_pkg::SRC_XTAL] = periph_set[tvui_pkg::SRC_XTAL] | crystal_ready_flag;
        hw_set[tvui_pkg::SRC_UNUSED] = 1'b0;
    end

    // next flags: write, vector clear, then set wins
    always_comb begin
        pend_d = (pend_q & ~sw_mask) | (sw_val & sw_mask); // see RULE_22
        if (ack_take && idx_q == 5'(tvui_pkg::SRC_PIN_A) && trig_q[0]) begin
            pend_d[tvui_pkg::SRC_PIN_A] = 1'b0; // see RULE_03
        end
        if (ack_take && idx_q == 5'(tvui_pkg::SRC_PIN_B) && trig_q[1]) begin
            pend_d[tvui_pkg::SRC_PIN_B] = 1'b0; // see RULE_03
        end
        pend_d = pend_d | hw_set; // set regardless of enable, see RULE_20
        if (!trig_q[0]) begin
            pend_d[tvui_pkg::SRC_PIN_A] = pin_low[0]; // see RULE_04
        end
        if (!trig_q[1]) begin
            pend_d[tvui_pkg::SRC_PIN_B] = pin_low[1]; // see RULE_04
        end
        pend_d[tvui_pkg::SRC_UNUSED] = 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= tvui_pkg::RST_SRC;
        end else begin
            pend_q <= pend_d;
        end
    end

    // ****************************************************************
    // arbitration, every clock
    // ****************************************************************
    assign elig = pend_q & en_q & {22{glob_q}}; // see RULE_20, RULE_21

    tvui_arb u_arb (
        .req    (elig),
        .pri    (pri_q),
        .ins_lo (ins_lo_q),
        .ins_hi (ins_hi_q),
        .win    (win)
    );

    // ****************************************************************
    // core handshake and in-service markers
    // ****************************************************************
    assign ack_take = call_ack & req_q;

    // request, vector, hold after return, markers
    always_comb begin
        req_d = win.valid & ~hold_q & ~irq_return_instr_done & ~call_ack; // see RULE_15, RULE_16
        idx_d = win.idx;
        hi_d  = win.hi;
        vec_d = tvui_pkg::vec_of(win.idx); // see RULE_08, RULE_11, RULE_14
        hold_d = hold_q;
        if (irq_return_instr_done) begin
            hold_d = 1'b1; // see RULE_17, RULE_23
        end else if (instr_boundary) begin // see RULE_18
            hold_d = 1'b0;
        end
        ins_lo_d = ins_lo_q;
        ins_hi_d = ins_hi_q;
        if (irq_return_instr_done) begin
            if (ins_hi_q) begin
                ins_hi_d = 1'b0; // see RULE_24
            end else begin
                ins_lo_d = 1'b0;
            end
        end
        if (ack_take) begin
            if (hi_q) begin
                ins_hi_d = 1'b1; // see RULE_13, RULE_24
            end else begin
                ins_lo_d = 1'b1; // see RULE_19
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_q    <= 1'b0;
            idx_q    <= 5'h00;
            hi_q     <= 1'b0;
            vec_q    <= 16'h0000;
            hold_q   <= 1'b0;
            ins_lo_q <= 1'b0;
            ins_hi_q <= 1'b0;
        end else begin
            req_q    <= req_d; // see RULE_25
            idx_q    <= idx_d;
            hi_q     <= hi_d;
            vec_q    <= vec_d;
            hold_q   <= hold_d;
            ins_lo_q <= ins_lo_d;
            ins_hi_q <= ins_hi_d;
        end
    end

    // outputs straight from flops
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign call_req      = req_q;
    assign call_vector   = vec_q;
    assign in_service_lo = ins_lo_q;
    assign in_service_hi = ins_hi_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_level_mirror;
        !trig_q[0] && !$past(wr_en) |=> pend_q[0] == $past(pin_low[0]);
    endproperty
    a_level_mirror: assert property (p_level_mirror) // see RULE_04
        else $error("level pending does not follow pin a");

    property p_edge_clear;
        ack_take && idx_q == 5'h00 && trig_q[0] && !pin_fall[0] && !wr_en |=> !pend_q[0];
    endproperty
    a_edge_clear: assert property (p_edge_clear) // see RULE_03
        else $error("edge pending of pin a not cleared on vectoring");

    property p_global_off;
        !glob_q |=> !req_q;
    endproperty
    a_global_off: assert property (p_global_off) // see RULE_21
        else $error("request raised with global enable off");

    property p_vector;
        req_q |-> vec_q == 16'h0003 + {8'h00, idx_q, 3'h0};
    endproperty
    a_vector: assert property (p_vector) // see RULE_08
        else $error("vector does not match source slot");

    property p_hi_block;
        ins_hi_q |=> !req_q;
    endproperty
    a_hi_block: assert property (p_hi_block) // see RULE_13
        else $error("request raised during high level routine");

    sequence s_return;
        irq_return_instr_done ##1 !instr_boundary;
    endsequence
    property p_return_hold;
        s_return |=> !req_q;
    endproperty
    a_return_hold: assert property (p_return_hold) // see RULE_17
        else $error("call requested before one instruction after return");

    property p_ack_marks;
        ack_take && !irq_return_instr_done |=> ($past(hi_q) ? ins_hi_q : ins_lo_q);
    endproperty
    a_ack_marks: assert property (p_ack_marks) // see RULE_24
        else $error("in-service marker not set on vectoring");

    property p_set_wins;
        pin_fall[2] |=> pend_q[16];
    endproperty
    a_set_wins: assert property (p_set_wins) // see RULE_07
        else $error("falling edge on ext4 lost");

    property p_soft_set;
        wr_en && paddr == tvui_pkg::ADDR_PEND && pwdata[5] |=> pend_q[5];
    endproperty
    a_soft_set: assert property (p_soft_set) // see RULE_22
        else $error("software set of pending flag lost");

    property p_detect;
        win.valid && !hold_q && !irq_return_instr_done && !call_ack |=> req_q;
    endproperty
    a_detect: assert property (p_detect) // see RULE_16
        else $error("eligible request not presented next clock");

endmodule : tvui_unit
`default_nettype wire

// ==== tvui_core_model.sv ====
// tvui_core_model: behavioural core, takes calls at instruction boundaries.
// assumes: same mclk and rst_n as the unit; returns are driven by the bench.
`timescale 1ns/1ns
`default_nettype none
module tvui_core_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        call_req,
    input  wire logic [15:0] call_vector,
    output logic             instr_boundary,
    output logic             call_ack,
    output logic      [15:0] got_vec,
    output logic      [7:0]  n_ack
);
    // ****************************************************************
    // boundary every other clock, one ack per request at a boundary
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instr_boundary <= 1'b0;
            call_ack       <= 1'b0;
            got_vec        <= 16'h0000;
            n_ack          <= 8'h00;
        end else begin
            instr_boundary <= ~instr_boundary;
            call_ack       <= call_req & instr_boundary & ~call_ack;
            if (call_req & instr_boundary & ~call_ack) begin
                got_vec <= call_vector; // vector taken as the call starts
                n_ack   <= n_ack + 8'h01;
            end
        end
    end
endmodule : tvui_core_model
`default_nettype wire

// ==== test_two_level_vectored_interrupt_unit.sv ====
// test_two_level_vectored_interrupt_unit: directed bench for the unit.
// assumes: unit and core model share mclk; apb master lives here.
`timescale 1ns/1ns
`default_nettype none
module test_two_level_vectored_interrupt_unit;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, err_seen, call_req, call_ack, instr_boundary;
    logic        in_service_lo, in_service_hi, irq_return_instr_done = 1'b0;
    logic        ext_req_pin_a_n = 1'b1, crystal_ready_flag = 1'b0, timer_two_ext_flag = 1'b0;
    logic [15:0] call_vector, got_vec;
    logic [7:0]  n_ack;
    logic [3:0]  ext47_pin_n = 4'hf;
    int          n_mismatch = 0, samples_checked = 0;
    // ****************************************************************
    // clock, unit and core model
    // ****************************************************************
    always #20 mclk = ~mclk;
    tvui_unit uut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_req_pin_a_n, .ext_req_pin_b_n(1'b1), .ext47_pin_n,
        .periph_set(22'h000000), .timer_two_overflow_flag(1'b0), .timer_two_ext_flag,
        .counter_array_overflow(1'b0), .counter_module_flag(5'h00), .crystal_ready_flag,
        .instr_boundary, .call_ack, .irq_return_instr_done, .call_req, .call_vector, .in_service_lo,
        .in_service_hi);
    tvui_core_model core (.mclk, .rst_n, .call_req, .call_vector, .instr_boundary,
        .call_ack, .got_vec, .n_ack);
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (n >= 20) begin
            n_mismatch++;
            conclude();
        end
    endtask : apb
    task automatic wait_ack(input logic [7:0] k);
        int n;
        n = 0;
        while (n_ack !== k && n < 60) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        if (n >= 60) begin
            n_mismatch++;
            conclude();
        end
    endtask : wait_ack
    task automatic irq_return_instr();
        irq_return_instr_done <= 1'b1;
        @(posedge mclk);
        irq_return_instr_done <= 1'b0;
        @(posedge mclk);
    endtask : irq_return_instr
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_and_soft();
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        apb(1'b1, 8'h04, 32'h82);
        apb(1'b1, 8'h00, 32'h20);
        wait_ack(8'h01);
        chk({16'h0, got_vec}, 32'h000b);
        chk({31'h0, in_service_lo}, 32'h1);
        apb(1'b1, 8'h00, 32'h00);
        irq_return_instr();
        chk({31'h0, in_service_lo}, 32'h0);
    endtask : t_reset_and_soft
    // level pin held across a return re-enters, then edge mode clears
    task automatic t_pin_a();
        apb(1'b1, 8'h04, 32'h81);
        ext_req_pin_a_n <= 1'b0;
        wait_ack(8'h02);
        chk({16'h0, got_vec}, 32'h0003);
        irq_return_instr();
        wait_ack(8'h03);
        ext_req_pin_a_n <= 1'b1;
        repeat (4) @(posedge mclk);
        irq_return_instr();
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h00);
        apb(1'b1, 8'h00, 32'h01);
        ext_req_pin_a_n <= 1'b0;
        wait_ack(8'h04);
        ext_req_pin_a_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h01);
        irq_return_instr();
    endtask : t_pin_a
    // disabled flags, high level first, high routine not preempted
    task automatic t_prio();
        apb(1'b1, 8'h04, 32'h20);
        crystal_ready_flag <= 1'b1;
        timer_two_ext_flag <= 1'b1;
        ext47_pin_n <= 4'he;
        @(posedge mclk);
        crystal_ready_flag <= 1'b0;
        timer_two_ext_flag <= 1'b0;
        apb(1'b1, 8'h0c, 32'h80);
        apb(1'b0, 8'h1c, 32'h0);
        chk(r, 32'h210020);
        chk({24'h0, n_ack}, 32'h04);
        apb(1'b0, 8'h20, 32'h0);
        chk(r, 32'h10);
        apb(1'b1, 8'h18, 32'h80);
        apb(1'b1, 8'h04, 32'ha0);
        wait_ack(8'h05);
        chk({16'h0, got_vec}, 32'h00ab);
        chk({31'h0, in_service_hi}, 32'h1);
        repeat (10) @(posedge mclk);
        chk({24'h0, n_ack}, 32'h05);
        apb(1'b1, 8'h1c, 32'h20);
        irq_return_instr();
        wait_ack(8'h06);
        chk({16'h0, got_vec}, 32'h002b);
    endtask : t_prio
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset_and_soft();
        t_pin_a();
        t_prio();
        conclude();
    end
endmodule : test_two_level_vectored_interrupt_unit
`default_nettype wire
